// ==== src/pmt_map.svh ====
// Register map, field positions and reset values of the prescaled match timer.
// Assumes byte addresses on a 32-bit APB; every register takes one aligned word.
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

`define PMT_ADDR_FLAGS      32'h4001_4000
`define PMT_ADDR_RUN        32'h4001_4004
`define PMT_ADDR_COUNT      32'h4001_4008
`define PMT_ADDR_LIMIT      32'h4001_400C
`define PMT_ADDR_DIVCNT     32'h4001_4010
`define PMT_ADDR_MATCHCTL   32'h4001_4014
`define PMT_ADDR_CMP0       32'h4001_4018
`define PMT_ADDR_CMP_STEP   32'h0000_0004
`define PMT_ADDR_MASK       32'h4001_4080

`define PMT_RUN_COUNT_EN    0
`define PMT_RUN_COUNT_CLR   1
`define PMT_FLAG_MATCH_LSB  0
`define PMT_FLAG_CAPT_LSB   4
`define PMT_FLAG_W          7
`define PMT_MCTL_W          12
`define PMT_MCTL_IRQ        0
`define PMT_MCTL_CLEAR      1
`define PMT_MCTL_HALT       2
`define PMT_MCTL_STRIDE     3
`define PMT_NUM_MATCH       4

`define PMT_RST_WORD        32'h0000_0000
`define PMT_RST_FLAGS       7'h00
`define PMT_RST_MCTL        12'h000

`endif

// ==== src/pmt_pkg.sv ====
// Types shared by the prescaled match timer core.
// Assumes pmt_map.svh is on the include path.
`include "pmt_map.svh"

package pmt_pkg;

	typedef logic [31:0] pmt_word_t;

	typedef struct packed {
		logic      sel;
		logic      enable;
		logic      write;
		pmt_word_t addr;
		pmt_word_t wdata;
	} pmt_apb_req_s;

	typedef struct packed {
		logic [`PMT_NUM_MATCH-1:0] irq_en;
		logic [`PMT_NUM_MATCH-1:0] clr_en;
		logic [`PMT_NUM_MATCH-1:0] halt_en;
	} pmt_match_s;

	typedef struct packed {
		logic [`PMT_FLAG_W-1:0]                event_flags;
		logic [`PMT_FLAG_W-1:0]                irq_mask;
		logic                                  count_enable;
		logic                                  count_clear;
		pmt_word_t                             main_count_value;
		pmt_word_t                             divider_limit;
		pmt_word_t                             tick_divider_count;
		logic [`PMT_MCTL_W-1:0]                match_action_ctrl;
		logic [`PMT_NUM_MATCH-1:0][31:0]       compare_value;
		logic [`PMT_NUM_MATCH-1:0]             hit_seen;
		logic                                  pready;
		logic                                  pslverr;
		pmt_word_t                             prdata;
		logic                                  irq;
	} pmt_state_s;

endpackage

// ==== src/pmt_core.sv ====
// Prescaled match timer core: 32-bit prescaler, 32-bit main counter, four match channels,
// sticky event flags with mask and one level interrupt, all behind an APB slave.
// Assumes pclk at 200 MHz, APB signals synchronous to pclk, ce freezes every flip-flop.
//
// Overview of operation
// - Flag set on source event, held until cleared.
// - Writing one clears flag, zero leaves it.
// - Match flags 0-3 in bits 0-3, reset zero.
// - Capture flags in bits 4-6, upper reserved.
// - Control bit 0 enables both counters.
// - Control bit 1 holds both counters cleared.
// - Main counter steps at prescaler terminal count.
// - Main counter wraps silently to zero.
// - Prescaler counts, returns zero at limit.
// - Main counter advances every limit+1 clocks.
// - Match-control bit 0 enables match-0 interrupt.
// - Match-control bit 1 clears counter on match.
// - Match-control bit 2 stops counters, clears enable.
// - Bits 3 and 4 do channel 1 likewise.
// - Bit 5, bits 6-11 serve channels 1-3.
// - Compare values checked continuously against counter.
`timescale 1ns/100ps
`include "pmt_map.svh"

module pmt_core
	import pmt_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);

	pmt_state_s                st_ff;
	pmt_state_s                nxt_st;
	pmt_apb_req_s              req;
	pmt_match_s                mctl;
	logic [`PMT_NUM_MATCH-1:0] hit;
	logic [`PMT_NUM_MATCH-1:0] hit_event;

	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

	// Per-channel comparator and action enables
	genvar gi;
	generate
		for (gi = 0; gi < `PMT_NUM_MATCH; gi++) begin : g_match
			assign hit[gi] = (st_ff.compare_value[gi] == st_ff.main_count_value);
			assign hit_event[gi] = hit[gi] & ~st_ff.hit_seen[gi];
			assign mctl.irq_en[gi] =
				st_ff.match_action_ctrl[gi*`PMT_MCTL_STRIDE + `PMT_MCTL_IRQ];
			assign mctl.clr_en[gi] =
				st_ff.match_action_ctrl[gi*`PMT_MCTL_STRIDE + `PMT_MCTL_CLEAR];
			assign mctl.halt_en[gi] =
				st_ff.match_action_ctrl[gi*`PMT_MCTL_STRIDE + `PMT_MCTL_HALT];
		end
	endgenerate

	always_comb begin
		logic                      setup;
		logic                      wr;
		logic                      mapped;
		logic                      any_halt;
		logic                      any_clr;
		logic                      tick;
		logic [`PMT_FLAG_W-1:0]    flag_set;
		logic [`PMT_FLAG_W-1:0]    flag_clr;
		pmt_word_t                 rdata;
		setup    = 1'b0;
		wr       = 1'b0;
		mapped   = 1'b0;
		any_halt = 1'b0;
		any_clr  = 1'b0;
		tick     = 1'b0;
		flag_set = '0;
		flag_clr = '0;
		rdata    = '0;
		nxt_st   = st_ff;

		setup = req.sel & ~req.enable;
		wr    = req.sel & req.enable & st_ff.pready & req.write;

		// Match events: one per arrival of equality
		nxt_st.hit_seen = hit;
		flag_set[`PMT_FLAG_MATCH_LSB +: `PMT_NUM_MATCH] = hit_event & mctl.irq_en;
		any_halt = |(hit_event & mctl.halt_en);
		any_clr  = |(hit & mctl.clr_en);

		// Sticky flags; a new event wins over a clear in the same cycle
		if (wr && req.addr == `PMT_ADDR_FLAGS) begin
			flag_clr = req.wdata[`PMT_FLAG_W-1:0];
		end
		nxt_st.event_flags = (st_ff.event_flags & ~flag_clr) | flag_set;

		if (wr && req.addr == `PMT_ADDR_MASK) begin
			nxt_st.irq_mask = req.wdata[`PMT_FLAG_W-1:0];
		end
		if (wr && req.addr == `PMT_ADDR_MATCHCTL) begin
			nxt_st.match_action_ctrl = req.wdata[`PMT_MCTL_W-1:0];
		end
		if (wr && req.addr == `PMT_ADDR_LIMIT) begin
			nxt_st.divider_limit = req.wdata;
		end
		for (int i = 0; i < `PMT_NUM_MATCH; i++) begin
			if (wr && req.addr == `PMT_ADDR_CMP0 + 32'(i) * `PMT_ADDR_CMP_STEP) begin
				nxt_st.compare_value[i] = req.wdata;
			end
		end

		// Run control; a halt from a match wins over a software enable
		if (wr && req.addr == `PMT_ADDR_RUN) begin
			nxt_st.count_enable = req.wdata[`PMT_RUN_COUNT_EN];
			nxt_st.count_clear  = req.wdata[`PMT_RUN_COUNT_CLR];
		end
		if (any_halt) begin
			nxt_st.count_enable = 1'b0;
		end

		// Counters
		tick = st_ff.count_enable & ~any_halt
			& (st_ff.tick_divider_count == st_ff.divider_limit);
		if (st_ff.count_clear) begin
			nxt_st.main_count_value   = '0;
			nxt_st.tick_divider_count = '0;
		end else begin
			if (wr && req.addr == `PMT_ADDR_COUNT) begin
				nxt_st.main_count_value = req.wdata;
			end else if (tick) begin
				if (any_clr) begin
					nxt_st.main_count_value = '0;
				end else begin
					nxt_st.main_count_value = st_ff.main_count_value + 32'h0000_0001;
				end
			end
			if (wr && req.addr == `PMT_ADDR_DIVCNT) begin
				nxt_st.tick_divider_count = req.wdata;
			end else if (tick) begin
				nxt_st.tick_divider_count = '0;
			end else if (st_ff.count_enable && !any_halt) begin
				nxt_st.tick_divider_count = st_ff.tick_divider_count + 32'h0000_0001;
			end
		end

		// Read decode at the setup edge; answer stands in the first access cycle
		mapped = 1'b1;
		unique case (req.addr)
			`PMT_ADDR_FLAGS:    rdata = {25'h0000000, st_ff.event_flags};
			`PMT_ADDR_RUN:      rdata = {30'h00000000, st_ff.count_clear, st_ff.count_enable};
			`PMT_ADDR_COUNT:    rdata = st_ff.main_count_value;
			`PMT_ADDR_LIMIT:    rdata = st_ff.divider_limit;
			`PMT_ADDR_DIVCNT:   rdata = st_ff.tick_divider_count;
			`PMT_ADDR_MATCHCTL: rdata = {20'h00000, st_ff.match_action_ctrl};
			`PMT_ADDR_MASK:     rdata = {25'h0000000, st_ff.irq_mask};
			default: begin
				mapped = 1'b0;
				for (int i = 0; i < `PMT_NUM_MATCH; i++) begin
					if (req.addr == `PMT_ADDR_CMP0 + 32'(i) * `PMT_ADDR_CMP_STEP) begin
						mapped = 1'b1;
						rdata  = st_ff.compare_value[i];
					end
				end
			end
		endcase

		nxt_st.pready = setup;
		if (setup) begin
			nxt_st.pslverr = ~mapped;
			nxt_st.prdata  = (mapped && !req.write) ? rdata : '0;
		end else begin
			nxt_st.pslverr = 1'b0;
		end

		nxt_st.irq = |(nxt_st.event_flags & nxt_st.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign prdata  = st_ff.prdata;
	assign pready  = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign irq     = st_ff.irq;

endmodule

// ==== dv/pmt_monitor.sv ====
// Checker of APB answer timing, reserved read bits and interrupt at reset.
// Assumes binding to every pmt_core, one pclk domain.
`timescale 1ns/100ps
`include "pmt_map.svh"
module pmt_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_ack = pready && !pwrite;
	a_setup_ready: assert property (psel && !penable && ce |=> pready) else $error("no pready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
	a_unmapped_err: assert property (pready && paddr == 32'h4001_4030 |-> pslverr)
		else $error("no pslverr");
	a_flag_rsvd: assert property (
		rd_ack && paddr == `PMT_ADDR_FLAGS |-> prdata[31:7] == '0) else $error("flag rsvd");
	a_run_rsvd: assert property (
		rd_ack && paddr == `PMT_ADDR_RUN |-> prdata[31:2] == '0) else $error("run rsvd");
	a_mctl_rsvd: assert property (
		rd_ack && paddr == `PMT_ADDR_MATCHCTL |-> prdata[31:12] == '0) else $error("mctl rsvd");
	a_irq_reset: assert property ($rose(presetn) |-> !irq) else $error("irq at reset");
	c_error_seen: cover property (pready && pslverr);
	c_irq_rise: cover property ($rose(irq));
	c_flag_read: cover property (rd_ack && paddr == `PMT_ADDR_FLAGS && prdata[1]);
endmodule

bind pmt_core pmt_monitor i_pmt_monitor (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq));

// ==== dv/test_pmt_core.sv ====
// Self-checking bench of the match timer core, driven over APB with random limits.
// Assumes pmt_core and the bound checker are compiled before it.
`timescale 1ns/100ps
`include "pmt_map.svh"
module test_pmt_core;
	localparam logic [31:0] B = `PMT_ADDR_FLAGS;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, q;
	logic        pready, pslverr, irq, e;
	logic        ce = 1'b1;
	int          mismatches = 0, checked = 0, seed = 32'h5ec6, lim, c0, c1, n;
	always #2.5 pclk = ~pclk;
	pmt_core i_pmt_core (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (int k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge pclk);
		if (pready !== 1'b1)
			mismatches++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string s, input logic [31:0] a, input logic [31:0] x);
		apb(1'b0, a, '0);
		cmp(s, x, q);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 10; i++)
			chk("reset", B + 4 * i, '0);
		apb(1'b0, 32'h4001_4030, '0);
		cmp("pslverr", 1, e);
		apb(1'b1, B + 'h14, 32'hFFFF_FFFF);
		chk("mctl", B + 'h14, 32'h0000_0FFF);
		lim = $random(seed) & 3;
		c0 = 3 + ($random(seed) & 7);
		apb(1'b1, B + 'h14, 32'h0000_0005);
		apb(1'b1, B + 'h18, c0);
		apb(1'b1, B + 'h0C, lim);
		apb(1'b1, `PMT_ADDR_MASK, 32'h0000_0001);
		apb(1'b1, B + 'h04, 32'h0000_0001);
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(posedge pclk);
			#1;
			n++;
		end
		@(posedge pclk);
		cmp("ticks", c0 * (lim + 1), n);
		chk("count", B + 'h08, c0);
		chk("divider", B + 'h10, '0);
		chk("run", B + 'h04, '0);
		apb(1'b1, B, '0);
		chk("flag kept", B, 32'h1);
		cmp("irq high", 1, irq);
		apb(1'b1, B, 32'h1);
		chk("flag clr", B, '0);
		cmp("irq low", 0, irq);
		c1 = 2 + ($random(seed) & 7);
		apb(1'b1, B + 'h04, 32'h0000_0002);
		chk("clr count", B + 'h08, '0);
		chk("clr divider", B + 'h10, '0);
		apb(1'b1, B + 'h1C, c1);
		apb(1'b1, B + 'h20, c1);
		apb(1'b1, B + 'h14, 32'h0000_0058);
		apb(1'b1, B + 'h0C, '0);
		apb(1'b1, B + 'h04, 32'h0000_0001);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, B + 'h08, '0);
			cmp("below match", 1, q <= c1);
		end
		chk("two flags", B, 32'h6);
		apb(1'b1, B + 'h04, '0);
		apb(1'b1, B, 32'hFFFF_FFFF);
		chk("flags zero", B, '0);
		apb(1'b1, B + 'h14, '0);
		apb(1'b1, B + 'h08, 32'hFFFF_FFFE);
		apb(1'b1, B + 'h04, 32'h0000_0001);
		apb(1'b1, B + 'h04, '0);
		apb(1'b0, B + 'h08, '0);
		cmp("wrap", 1, q < 32'h10);
		chk("wrap flag", B, '0);
		// Clock enable low must freeze the running counter
		apb(1'b1, B + 'h08, '0);
		apb(1'b1, B + 'h04, 32'h0000_0001);
		ce <= 1'b0;
		repeat (50) @(posedge pclk);
		ce <= 1'b1;
		apb(1'b0, B + 'h08, '0);
		cmp("freeze", 32'h0000_0001, q);
		apb(1'b1, B + 'h04, '0);
		test_done();
	end
	initial begin
		#20000;
		mismatches++;
		test_done();
	end
endmodule
